// ===== core/gdt_consts.svh
`ifndef GDT_CONSTS_SVH
`define GDT_CONSTS_SVH

// slave address upper six bits, low bit from the address-select pin
`define GDT_ADDR_HI 6'h3A
`define GDT_GCALL_ADDR 8'h00
`define GDT_GCALL_RESET 8'h06
// master code pattern 00001xxx, upper five bits
`define GDT_HS_CODE_HI 5'h01
`define GDT_CODE_W 10
`define GDT_CHANNELS 9
`define GDT_MIDSCALE 10'h200
`define GDT_FULL_SCALE 1024
`define GDT_MAX_PROGRAMS 16
`define GDT_CLK_HZ 10000000
// power-on load time of both banks, microseconds
`define GDT_LOAD_US 560
`define GDT_LOAD_CYC ((`GDT_LOAD_US * (`GDT_CLK_HZ / 1000000)))
// bank switch limit, microseconds; met in a few cycles by construction
`define GDT_SWITCH_US 5
`define GDT_SWITCH_CYC ((`GDT_SWITCH_US * (`GDT_CLK_HZ / 1000000)))

`endif

// ===== core/gdt_pkg.sv
package gdt_pkg;
	typedef logic [9:0] gdt_code_t;
	typedef enum logic [5:0]
	{
		GDT_IDLE = 6'h01,
		GDT_ADDR = 6'h02,
		GDT_AACK = 6'h04,
		GDT_DATA = 6'h08,
		GDT_DACK = 6'h10,
		GDT_SKIP = 6'h20
	} gdt_state_t;
endpackage

// ===== core/gdt_bus_if.sv
interface gdt_bus_if;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	modport det
	(
		input scl,
		input sda,
		output start,
		output stop,
		output scl_rise,
		output scl_fall
	);
	modport eng
	(
		output scl,
		output sda,
		input start,
		input stop,
		input scl_rise,
		input scl_fall
	);
endinterface

// ===== core/gdt_cond_detect.sv
`include "gdt_consts.svh"
module gdt_cond_detect
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	gdt_bus_if.det bus
);
	logic scl_d;
	logic sda_d;
	logic next_scl_d;
	logic next_sda_d;

	always_comb
	begin
		next_scl_d = bus.scl;
		next_sda_d = bus.sda;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end
		else
		begin
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
		end
	end

	assign bus.start = scl_d && bus.scl && sda_d && !bus.sda;
	assign bus.stop = scl_d && bus.scl && !sda_d && bus.sda;
	assign bus.scl_rise = !scl_d && bus.scl;
	assign bus.scl_fall = scl_d && !bus.scl;
endmodule

// ===== core/gdt_twowire_slave.sv
`include "gdt_consts.svh"
module gdt_twowire_slave
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_address_select_pin,
	input wire logic i_bank_choice_pin,
	input wire logic [89:0] i_nv_bank0,
	input wire logic [89:0] i_nv_bank1,
	input wire logic [8:0] i_nv_programmed0,
	input wire logic [8:0] i_nv_programmed1,
	output logic [79:0] o_gamma_output_channel,
	output logic [9:0] o_common_electrode_output,
	output logic o_hs_mode,
	output logic o_load_busy
);
	// no clock output exists; the clock line is input only
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] a0_sync;
	logic [1:0] bk_sync;
	logic [1:0] next_scl_sync;
	logic [1:0] next_sda_sync;
	logic [1:0] next_a0_sync;
	logic [1:0] next_bk_sync;

	always_comb
	begin
		next_scl_sync = {scl_sync[0], i_scl};
		next_sda_sync = {sda_sync[0], i_sda};
		next_a0_sync = {a0_sync[0], i_address_select_pin};
		next_bk_sync = {bk_sync[0], i_bank_choice_pin};
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			a0_sync <= 2'h0;
			bk_sync <= 2'h0;
		end
		else
		begin
			scl_sync <= next_scl_sync;
			sda_sync <= next_sda_sync;
			a0_sync <= next_a0_sync;
			bk_sync <= next_bk_sync;
		end
	end

	gdt_bus_if bus ();
	assign bus.scl = scl_sync[1];
	assign bus.sda = sda_sync[1];

	gdt_cond_detect u_det
	(
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.bus(bus)
	);

	gdt_pkg::gdt_state_t state;
	gdt_pkg::gdt_state_t next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic ack;
	logic next_ack;
	logic gcall;
	logic next_gcall;
	logic hs;
	logic next_hs;
	logic gc_reset;
	logic [7:0] byte_in;
	logic addr_hit;
	logic hs_code;

	assign byte_in = {shreg[6:0], bus.sda};
	// own address with pin-selected low bit
	assign addr_hit = shreg[7:1] == {`GDT_ADDR_HI, a0_sync[1]};
	assign hs_code = shreg[7:3] == `GDT_HS_CODE_HI;

	always_comb
	begin
		next_state = state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_ack = ack;
		next_gcall = gcall;
		next_hs = hs;
		gc_reset = 1'h0;
		// any change while clock is high is a condition
		if (bus.stop)
		begin
			next_state = gdt_pkg::GDT_IDLE;
			next_ack = 1'h0;
			next_hs = 1'h0;
		end
		else if (bus.start)
		begin
			// start opens an address byte; hs kept across repeats
			next_state = gdt_pkg::GDT_ADDR;
			next_bitcnt = 4'h0;
			next_ack = 1'h0;
			next_gcall = 1'h0;
		end
		else
		begin
			unique case (state)
				gdt_pkg::GDT_IDLE, gdt_pkg::GDT_SKIP:
				begin
				end
				gdt_pkg::GDT_ADDR, gdt_pkg::GDT_DATA:
				begin
					if (bus.scl_rise)
					begin
						next_shreg = byte_in;
						next_bitcnt = bitcnt + 4'h1;
					end
					// eighth bit done, ack slot follows
					if (bus.scl_fall && bitcnt == 4'h8)
					begin
						next_bitcnt = 4'h0;
						if (state == gdt_pkg::GDT_ADDR)
						begin
							next_state = gdt_pkg::GDT_AACK;
							if (hs_code)
							begin
								next_hs = 1'h1;
								next_ack = 1'h0;
								next_state = gdt_pkg::GDT_SKIP;
							end
							else if (shreg == `GDT_GCALL_ADDR)
							begin
								next_ack = 1'h1;
								next_gcall = 1'h1;
							end
							else if (addr_hit)
								next_ack = 1'h1;
							// ack stays low; ignore until next start
							else
								next_state = gdt_pkg::GDT_SKIP;
						end
						else
						begin
							next_state = gdt_pkg::GDT_DACK;
							next_ack = !gcall || shreg == `GDT_GCALL_RESET;
						end
					end
				end
				gdt_pkg::GDT_AACK, gdt_pkg::GDT_DACK:
				begin
					// hold low through ninth high phase, release on fall
					if (bus.scl_fall)
					begin
						next_ack = 1'h0;
						next_state = gdt_pkg::GDT_DATA;
						// general-call reset acts after its ack
						if (gcall && state == gdt_pkg::GDT_DACK && ack)
							gc_reset = 1'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			state <= gdt_pkg::GDT_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			ack <= 1'h0;
			gcall <= 1'h0;
			hs <= 1'h0;
		end
		else
		begin
			state <= next_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			ack <= next_ack;
			gcall <= next_gcall;
			hs <= next_hs;
		end
	end

	// open-drain drive low only while acknowledging
	assign o_sda = 1'h0;
	assign o_sda_oe = ack;
	// no mode gating; rates bounded only by sampling
	assign o_hs_mode = hs;

	// power-on and general-call load sequence
	localparam int LOAD_CYC = `GDT_LOAD_CYC;
	logic [12:0] load_cnt;
	logic [12:0] next_load_cnt;
	logic loading;
	logic next_loading;
	gdt_pkg::gdt_code_t store0 [`GDT_CHANNELS];
	gdt_pkg::gdt_code_t store1 [`GDT_CHANNELS];
	gdt_pkg::gdt_code_t next_store0 [`GDT_CHANNELS];
	gdt_pkg::gdt_code_t next_store1 [`GDT_CHANNELS];
	gdt_pkg::gdt_code_t outv [`GDT_CHANNELS];
	gdt_pkg::gdt_code_t next_outv [`GDT_CHANNELS];

	always_comb
	begin
		next_load_cnt = load_cnt;
		next_loading = loading;
		// both banks read over the load time, then outputs updated
		if (gc_reset)
		begin
			next_loading = 1'h1;
			next_load_cnt = 13'h0000;
		end
		else if (loading)
		begin
			if (load_cnt == 13'(LOAD_CYC - 1))
				next_loading = 1'h0;
			else
				next_load_cnt = load_cnt + 13'h0001;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			load_cnt <= 13'h0000;
			loading <= 1'h1;
		end
		else
		begin
			load_cnt <= next_load_cnt;
			loading <= next_loading;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `GDT_CHANNELS; ch++)
		begin : g_ch
			always_comb
			begin
				next_store0[ch] = store0[ch];
				next_store1[ch] = store1[ch];
				if (loading && load_cnt == 13'(LOAD_CYC - 1))
				begin
					next_store0[ch] = i_nv_programmed0[ch] ? i_nv_bank0[ch*10 +: 10] :
						`GDT_MIDSCALE;
					next_store1[ch] = i_nv_programmed1[ch] ? i_nv_bank1[ch*10 +: 10] :
						`GDT_MIDSCALE;
				end
				// midscale from the busy edge until load completes
				if (gc_reset || loading)
					next_outv[ch] = `GDT_MIDSCALE;
				// switch from stored values, no memory reread
				else if (bk_sync[1])
					next_outv[ch] = store1[ch];
				else
					next_outv[ch] = store0[ch];
			end

			always_ff @(posedge i_sys_clk)
			begin
				if (i_srst)
				begin
					store0[ch] <= `GDT_MIDSCALE;
					store1[ch] <= `GDT_MIDSCALE;
					outv[ch] <= `GDT_MIDSCALE;
				end
				else
				begin
					store0[ch] <= next_store0[ch];
					store1[ch] <= next_store1[ch];
					outv[ch] <= next_outv[ch];
				end
			end

			// eight gamma codes, last channel is the common electrode
			// analog level is supply times code over 1024, outside logic
			if (ch < `GDT_CHANNELS - 1)
			begin : g_gamma
				assign o_gamma_output_channel[ch*10 +: 10] = outv[ch];
			end
			else
			begin : g_com
				assign o_common_electrode_output = outv[ch];
			end
		end
	endgenerate

	// memory programming lives outside this block, never issued here
	assign o_load_busy = loading;
endmodule

// ===== bench/gdt_twowire_slave_checker.sv
module gdt_twowire_slave_checker
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_address_select_pin,
	input wire logic i_bank_choice_pin,
	input wire logic [89:0] i_nv_bank0,
	input wire logic [89:0] i_nv_bank1,
	input wire logic [8:0] i_nv_programmed0,
	input wire logic [8:0] i_nv_programmed1,
	input wire logic [79:0] o_gamma_output_channel,
	input wire logic [9:0] o_common_electrode_output,
	input wire logic o_hs_mode,
	input wire logic o_load_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] busy_cnt;
	logic [12:0] next_busy_cnt;
	logic [9:0] exp_com;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_srst);
	always_comb
	begin
		next_busy_cnt = o_load_busy ? busy_cnt + 13'h1 : 13'h0;
		if (i_bank_choice_pin)
			exp_com = i_nv_programmed1[8] ? i_nv_bank1[89:80] : 10'h200;
		else
			exp_com = i_nv_programmed0[8] ? i_nv_bank0[89:80] : 10'h200;
	end
	always_ff @(posedge i_sys_clk)
		busy_cnt <= i_srst ? 13'h0 : next_busy_cnt;
	a_sda_low_only:
		assert property (o_sda_oe |-> o_sda == 1'b0) else $error("data line driven high");
	a_reset_state:
		assert property ($fell(i_srst) |-> o_load_busy && !o_hs_mode && !o_sda_oe)
		else $error("bad state after reset");
	a_mid_busy:
		assert property (o_load_busy |-> o_common_electrode_output == 10'h200
			&& o_gamma_output_channel == {8{10'h200}}) else $error("not midscale in load");
	a_load_max:
		assert property (o_load_busy |-> busy_cnt < 13'h15EA) else $error("load too long");
	a_load_len:
		assert property ($fell(o_load_busy) |-> busy_cnt >= 13'h15D6) else $error("load too short");
	a_bank_follow:
		assert property (!o_load_busy && $changed(i_bank_choice_pin)
			|-> ##[1:8] o_common_electrode_output == exp_com) else $error("bank switch late");
	a_hs_stop_exit:
		assert property (o_hs_mode && i_scl && $rose(i_sda) |-> ##[1:8] !o_hs_mode)
		else $error("fast mode kept after stop");
	a_ack_release_low:
		assert property ($fell(o_sda_oe) |-> !i_scl) else $error("ack released in clock high");
	a_ack_hold_min:
		assert property ($rose(o_sda_oe) |-> o_sda_oe [*6]) else $error("ack too short");
	cover property ($rose(o_sda_oe));
	cover property ($rose(o_hs_mode));
	cover property ($fell(o_load_busy));
endmodule

bind gdt_twowire_slave gdt_twowire_slave_checker chk
(
	.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_address_select_pin(i_address_select_pin),
	.i_bank_choice_pin(i_bank_choice_pin), .i_nv_bank0(i_nv_bank0), .i_nv_bank1(i_nv_bank1),
	.i_nv_programmed0(i_nv_programmed0), .i_nv_programmed1(i_nv_programmed1),
	.o_gamma_output_channel(o_gamma_output_channel),
	.o_common_electrode_output(o_common_electrode_output),
	.o_hs_mode(o_hs_mode), .o_load_busy(o_load_busy)
);

// ===== bench/gdt_bus_master.sv
module gdt_bus_master
(
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// half clock period in system cycles; raised for the slow master code
	int half = 4;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic start();
		o_sda = 1'b1;
		hold(half);
		o_scl = 1'b1;
		hold(half);
		o_sda = 1'b0;
		hold(half);
		o_scl = 1'b0;
	endtask
	// data moves only while clock low
	task automatic clk_bit(input logic b, output logic s);
		o_sda = b;
		hold(half);
		o_scl = 1'b1;
		hold(half / 2);
		s = i_sda;
		hold(half - half / 2);
		o_scl = 1'b0;
	endtask
	// eight bits msb first, then released for the ack
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic stop();
		o_sda = 1'b0;
		hold(half);
		o_scl = 1'b1;
		hold(half);
		o_sda = 1'b1;
		hold(half);
	endtask
endmodule

// ===== bench/gamma_dac_twowire_slave_tb.sv
module gamma_dac_twowire_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic a0 = 1'b0;
	logic bank = 1'b0;
	logic [89:0] nv0 = '0;
	logic [89:0] nv1 = '0;
	logic [8:0] pg0 = '0;
	logic [8:0] pg1 = '0;
	logic [79:0] gam;
	logic [9:0] com;
	logic sda_o, oe, hs, busy, m_scl, m_sda, sda_w, ack;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	int q[$] = '{8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hE6, 8'hF8};
	always #50 clk = ~clk;
	// open-drain wire with pull-up
	assign sda_w = m_sda & (oe ? sda_o : 1'b1);
	gdt_twowire_slave uut
	(
		.i_sys_clk(clk), .i_srst(srst), .i_scl(m_scl), .i_sda(sda_w), .o_sda(sda_o),
		.o_sda_oe(oe), .i_address_select_pin(a0), .i_bank_choice_pin(bank),
		.i_nv_bank0(nv0), .i_nv_bank1(nv1), .i_nv_programmed0(pg0), .i_nv_programmed1(pg1),
		.o_gamma_output_channel(gam), .o_common_electrode_output(com),
		.o_hs_mode(hs), .o_load_busy(busy)
	);
	gdt_bus_master m (.i_clk(clk), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	function automatic logic [9:0] exp_ch(input logic b, input int k);
		if (b ? pg1[k] : pg0[k])
			return b ? nv1[k*10+:10] : nv0[k*10+:10];
		return 10'h200;
	endfunction
	function automatic logic exp_ack(input int b);
		return logic'((b >> 1) == 116 + int'(a0));
	endfunction
	task automatic chk_outs(input logic b);
		logic [89:0] all;
		all = {com, gam};
		for (int k = 0; k < 9; k++)
			chk("channel", all[k*10+:10], exp_ch(b, k));
	endtask
	task automatic wait_load();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 6000)
		begin
			@(negedge clk);
			n++;
		end
		chk("load done", busy, 1'b0);
		// outputs take the bank values one edge after busy drops
		@(negedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			final_report();
		end
	end
	initial
	begin
		void'($urandom(32'h64928d13));
		nv0 = 90'({$urandom, $urandom, $urandom});
		nv1 = 90'({$urandom, $urandom, $urandom});
		pg0 = 9'($urandom) & 9'h1EF;
		pg1 = 9'($urandom) | 9'h001;
		q.push_back(int'(8'h80 | 8'($urandom)));
		repeat (10) @(negedge clk);
		srst = 1'b0;
		wait_load();
		chk_outs(1'b0);
		bank = 1'b1;
		repeat (8) @(negedge clk);
		chk_outs(1'b1);
		for (int a = 0; a < 2; a++)
		begin
			a0 = a[0];
			repeat (4) @(negedge clk);
			foreach (q[i])
			begin
				m.start();
				m.wbyte(8'(q[i]), ack);
				chk("addr ack", ack, exp_ack(q[i]));
				m.wbyte(8'($urandom), ack);
				chk("data ack", ack, exp_ack(q[i]));
				m.stop();
			end
		end
		for (int j = 0; j < 8; j++)
		begin
			m.half = 13;
			m.start();
			m.wbyte(8'h08 | 8'(j), ack);
			m.half = 4;
			m.hold(4);
			chk("code ack", ack, 1'b0);
			chk("fast on", hs, 1'b1);
			m.start();
			m.wbyte(8'hEA, ack);
			chk("fast addr", ack, 1'b1);
			chk("fast kept", hs, 1'b1);
			m.stop();
			m.hold(6);
			chk("fast off", hs, 1'b0);
		end
		m.start();
		m.wbyte(8'h00, ack);
		chk("call ack", ack, 1'b1);
		m.wbyte(8'h05, ack);
		chk("call other", ack, 1'b0);
		m.stop();
		chk("no reset", busy, 1'b0);
		m.start();
		m.wbyte(8'h00, ack);
		m.wbyte(8'h06, ack);
		chk("reset ack", ack, 1'b1);
		m.stop();
		chk("reset busy", busy, 1'b1);
		chk("midscale", com, 10'h200);
		wait_load();
		chk_outs(1'b1);
		final_report();
	end
endmodule
